// ---- logic/core_alu.sv ----
// Purpose: Operand addressing and ALU subset of a 16-bit signal controller core
// Assumes: Avalon-MM slave, word index addressing, commands written to CMD
// Notes: Each command executes one cycle after it is accepted
`timescale 1ns/100ps
// Summary of operation
// - Square uses one register W4..W7
// - Multiply pairs distinct, lower register first
// - Sixteen working registers, any selectable
// - File add and shift forms use W0; bit clear stays in f
// - X prefetch W8/W9, modify or W9+W12
// - Y prefetch W10/W11, modify or W11+W12
// - Prefetch destinations W4..W7
// - Accumulator signed add updates OA SA (acc A) or OB SB (acc B)
// - File add-with-carry sums f, W0, carry
// - Literal10 add-with-carry back to register
// - Three-operand add-with-carry to destination
// - File shift right keeps sign, CNOVZ
// - Register shift right one cycle
// - Shift by register count, N Z
// - Shift by literal5 count, N Z
// - Core flags C DC N OV sticky Z
// - DSP flags OA OB SA SB
module core_alu
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest
);
   import alu_pkg::*;
   logic [15:0] default_w0_operand [NREG];
   logic [15:0] freg;
   logic [39:0] acc_a;
   logic [39:0] acc_b;
   logic [15:0] pf_x;
   logic [15:0] pf_y;
   core_flags_t cflags;
   dsp_flags_t dflags;
   logic [31:0] cmd;
   logic busy;
   logic branch_stall;
   logic taken;
   logic illegal;
   logic ack;
   alu_out_t alu_res;
   op_t op;
   logic [3:0] src;
   logic [3:0] base;
   logic [3:0] dst;
   logic [9:0] lit;
   logic to_w0;
   logic [15:0] opa;
   logic [15:0] opb;
   logic [4:0] shamt;
   logic [39:0] acc_sel;
   logic [40:0] acc_sum;
   logic acc_ovf;
   logic [39:0] acc_new;
   logic [15:0] pf_addr;
   logic [3:0] pf_ptr;
   logic [3:0] pf_dst;
   logic legal;

   function automatic logic in_dsp_group(input logic [3:0] r);
      in_dsp_group = (r >= W4_IDX) && (r <= W7_IDX);
   endfunction

   function automatic logic [15:0] pf_mod(input logic [2:0] m, input logic [15:0] v);
      case (m)
         3'h1: pf_mod = v + 16'h0002;
         3'h2: pf_mod = v + 16'h0004;
         3'h3: pf_mod = v + 16'h0006;
         3'h5: pf_mod = v - 16'h0002;
         3'h6: pf_mod = v - 16'h0004;
         3'h7: pf_mod = v - 16'h0006;
         default: pf_mod = v;
      endcase
   endfunction

   assign op = op_t'(cmd[F_OP +: 4]);
   assign src = cmd[F_SRC +: 4];
   assign base = cmd[F_BASE +: 4];
   assign dst = cmd[F_DST +: 4];
   assign lit = cmd[F_LIT +: 10];
   assign to_w0 = cmd[F_TOW0];

   always_comb
   begin
      opa = default_w0_operand[base];
      opb = default_w0_operand[src];
      shamt = lit[4:0];
      legal = 1'b1;
      pf_ptr = W8_IDX;
      pf_dst = W4_IDX;
      pf_addr = ZERO16;
      case (op)
         OP_ADD_WITH_CARRY_IN_F:
         begin
            opa = freg;
            opb = default_w0_operand[W0_IDX];
         end
         OP_ADD_WITH_CARRY_IN_L10:
         begin
            opa = default_w0_operand[dst];
            opb = {6'h00, lit};
         end
         OP_ADD_WITH_CARRY_IN_L5:
         begin
            opb = {11'h000, lit[4:0]};
         end
         OP_ASR_F, OP_BIT_CLEAR_F:
         begin
            opa = freg;
            shamt = {1'b0, lit[3:0]};
         end
         OP_ASR_W, OP_BIT_CLEAR_W:
         begin
            opa = default_w0_operand[src];
            shamt = {1'b0, lit[3:0]};
         end
         OP_ASR_WN:
         begin
            shamt = default_w0_operand[src][4:0];
         end
         OP_MUL:
         begin
            opa = default_w0_operand[base];
            opb = default_w0_operand[src];
            legal = in_dsp_group(base) && in_dsp_group(src) && (base <= src);
         end
         OP_PREFETCH:
         begin
            pf_ptr = (lit[9] ? W10_IDX : W8_IDX) + {3'h0, lit[3]};
            pf_addr = (lit[2:0] == 3'h4) ? default_w0_operand[pf_ptr] + default_w0_operand[W12_IDX] : default_w0_operand[pf_ptr];
            pf_dst = W4_IDX + {2'h0, dst[1:0]};
            legal = !((lit[2:0] == 3'h4) && !lit[3]);
         end
         default:
         begin
            opa = default_w0_operand[base];
         end
      endcase
   end

   alu_unit u_alu
   (
      .op(op),
      .opa(opa),
      .opb(opb),
      .shamt(shamt),
      .fin(cflags),
      .res(alu_res)
   );

   always_comb
   begin
      acc_sel = cmd[F_ACC] ? acc_b : acc_a;
      if ($signed(lit[3:0]) < 0)
         acc_sum = {acc_sel[39], acc_sel}
            + ({{9{default_w0_operand[src][15]}}, default_w0_operand[src], 16'h0000} << (5'h10 - {1'b0, lit[3:0]}));
      else
         acc_sum = {acc_sel[39], acc_sel}
            + 41'($signed({{9{default_w0_operand[src][15]}}, default_w0_operand[src], 16'h0000}) >>> lit[3:0]);
      acc_ovf = acc_sum[40] != acc_sum[39];
      acc_new = acc_ovf ? (acc_sum[40] ? ACC_MIN : ACC_MAX) : acc_sum[39:0];
   end

   // Command accept
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cmd <= 32'h0000_0000;
      else if (write && !waitrequest && address == REG_CMD)
         cmd <= writedata;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         busy <= 1'b0;
      else if (write && !waitrequest && address == REG_CMD)
         busy <= 1'b1;
      else if (branch_stall || !(op == OP_BRA_C && cflags.c))
         busy <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         branch_stall <= 1'b0;
      else
         branch_stall <= busy && !branch_stall && op == OP_BRA_C && cflags.c;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         taken <= 1'b0;
         illegal <= 1'b0;
      end
      else if (busy && !branch_stall)
      begin
         taken <= (op == OP_BRA_C) && cflags.c;
         illegal <= !legal;
      end
   end

   // Working register file and file register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NREG; i++)
            default_w0_operand[i] <= ZERO16;
         freg <= ZERO16;
         pf_x <= ZERO16;
         pf_y <= ZERO16;
      end
      else if (write && !waitrequest && address[5:4] == REG_WBASE[5:4])
         default_w0_operand[address[3:0]] <= writedata[15:0];
      else if (write && !waitrequest && address == REG_FREG)
         freg <= writedata[15:0];
      else if (busy && !branch_stall)
      begin
         case (op)
            OP_ADD_WITH_CARRY_IN_F, OP_ASR_F, OP_BIT_CLEAR_F:
            begin
               if (to_w0 && op != OP_BIT_CLEAR_F)
                  default_w0_operand[W0_IDX] <= alu_res.result;
               else
                  freg <= alu_res.result;
            end
            OP_ADD_WITH_CARRY_IN_L10, OP_ADD_WITH_CARRY_IN_W, OP_ADD_WITH_CARRY_IN_L5, OP_ASR_W, OP_ASR_WN, OP_ASR_L5, OP_AND_W:
               default_w0_operand[dst] <= alu_res.result;
            OP_BIT_CLEAR_W:
               default_w0_operand[src] <= alu_res.result;
            OP_PREFETCH:
            begin
               if (legal && lit[2:0] != 3'h4)
                  default_w0_operand[pf_ptr] <= pf_mod(lit[2:0], default_w0_operand[pf_ptr]);
               if (legal && lit[9])
                  pf_y <= pf_addr;
               else if (legal)
                  pf_x <= pf_addr;
               if (legal)
                  default_w0_operand[pf_dst] <= pf_addr;
            end
            default:
            begin
               freg <= freg;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cflags <= '0;
      else if (busy && !branch_stall)
         cflags <= alu_res.flags;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         acc_a <= ZERO40;
         acc_b <= ZERO40;
         dflags <= '0;
      end
      else if (busy && !branch_stall && op == OP_ACC_ADD)
      begin
         if (cmd[F_ACC])
         begin
            acc_b <= acc_new;
            dflags.acc_b_overflow <= acc_ovf;
            dflags.acc_b_clip_sticky <= dflags.acc_b_clip_sticky | acc_ovf;
         end
         else
         begin
            acc_a <= acc_new;
            dflags.acc_a_overflow <= acc_ovf;
            dflags.acc_a_clip_sticky <= dflags.acc_a_clip_sticky | acc_ovf;
         end
      end
   end

   // Bus answer: one wait cycle, then data
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         ack <= 1'b0;
      else
         ack <= (read || write) && !ack;
   end
   assign waitrequest = !ack;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         readdata <= 32'h0000_0000;
      else if (read && !ack)
      begin
         if (address[5:4] == REG_WBASE[5:4])
            readdata <= {16'h0000, default_w0_operand[address[3:0]]};
         else
            case (address)
               REG_CMD: readdata <= cmd;
               REG_STATUS: readdata <= {20'h00000, illegal, taken, busy,
                  dflags.acc_b_clip_sticky, dflags.acc_a_clip_sticky,
                  dflags.acc_b_overflow, dflags.acc_a_overflow,
                  cflags.dc, cflags.n, cflags.ov, cflags.z, cflags.c};
               REG_FREG: readdata <= {16'h0000, freg};
               REG_ACCA_LO: readdata <= acc_a[31:0];
               REG_ACCB_LO: readdata <= acc_b[31:0];
               REG_PFX: readdata <= {16'h0000, pf_x};
               REG_PFY: readdata <= {16'h0000, pf_y};
               default: readdata <= BAD_READ;
            endcase
      end
   end
endmodule // core_alu

// ---- logic/alu_pkg.sv ----
// Purpose: Shared types and constants for the operand and ALU datapath slice
// Assumes: 16-bit data, sixteen working registers, 40-bit accumulators
// Notes: Register offsets are word indices; byte address is four times
package alu_pkg;
   localparam int DW = 16;
   localparam int NREG = 16;
   localparam int ACCW = 40;
   localparam logic [3:0] W0_IDX = 4'h0;
   localparam logic [3:0] W4_IDX = 4'h4;
   localparam logic [3:0] W7_IDX = 4'h7;
   localparam logic [3:0] W8_IDX = 4'h8;
   localparam logic [3:0] W10_IDX = 4'hA;
   localparam logic [3:0] W12_IDX = 4'hC;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [39:0] ZERO40 = 40'h00_0000_0000;
   localparam logic [39:0] ACC_MAX = 40'h7F_FFFF_FFFF;
   localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;
   // Register word indices on the bus
   localparam logic [5:0] REG_CMD = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h01;
   localparam logic [5:0] REG_FREG = 6'h02;
   localparam logic [5:0] REG_ACCA_LO = 6'h03;
   localparam logic [5:0] REG_ACCB_LO = 6'h04;
   localparam logic [5:0] REG_PFX = 6'h05;
   localparam logic [5:0] REG_PFY = 6'h06;
   localparam logic [5:0] REG_WBASE = 6'h10;
   localparam logic [31:0] BAD_READ = 32'hDEAD_0000;
   // Command word fields
   localparam int F_OP = 0;
   localparam int F_SRC = 8;
   localparam int F_BASE = 12;
   localparam int F_DST = 16;
   localparam int F_LIT = 20;
   localparam int F_TOW0 = 30;
   localparam int F_ACC = 31;
   // Status bit positions
   localparam int S_C = 0;
   localparam int S_Z = 1;
   localparam int S_OV = 2;
   localparam int S_N = 3;
   localparam int S_DC = 4;
   localparam int S_OA = 5;
   localparam int S_OB = 6;
   localparam int S_SA = 7;
   localparam int S_SB = 8;
   localparam int S_BUSY = 9;
   localparam int S_TAKEN = 10;
   localparam int S_ILLEGAL = 11;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ADD_WITH_CARRY_IN_F = 4'h1, OP_ADD_WITH_CARRY_IN_L10 = 4'h2, OP_ADD_WITH_CARRY_IN_W = 4'h3,
      OP_ADD_WITH_CARRY_IN_L5 = 4'h4, OP_ASR_F = 4'h5, OP_ASR_W = 4'h6, OP_ASR_WN = 4'h7,
      OP_ASR_L5 = 4'h8, OP_AND_W = 4'h9, OP_BIT_CLEAR_W = 4'hA, OP_BIT_CLEAR_F = 4'hB,
      OP_BRA_C = 4'hC, OP_ACC_ADD = 4'hD, OP_MUL = 4'hE, OP_PREFETCH = 4'hF
   } op_t;

   typedef struct packed {
      logic c;
      logic z;
      logic ov;
      logic n;
      logic dc;
   } core_flags_t;

   typedef struct packed {
      logic acc_a_overflow;
      logic acc_b_overflow;
      logic acc_a_clip_sticky;
      logic acc_b_clip_sticky;
   } dsp_flags_t;

   typedef struct packed {
      logic [15:0] result;
      core_flags_t flags;
   } alu_out_t;
endpackage

// ---- logic/alu_unit.sv ----
// Purpose: Combinational add-with-carry, shift, AND and bit-clear unit
// Assumes: Operands already selected by the caller
// Notes: Flag merge with old flags happens here
`timescale 1ns/100ps
module alu_unit
(
   input wire alu_pkg::op_t op,
   input wire logic [15:0] opa,
   input wire logic [15:0] opb,
   input wire logic [4:0] shamt,
   input wire alu_pkg::core_flags_t fin,
   output alu_pkg::alu_out_t res
);
   import alu_pkg::*;
   logic [16:0] sum;
   logic [4:0] nib;
   logic [15:0] r;
   always_comb
   begin
      sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, fin.c};
      nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, fin.c};
      r = opa;
      res.flags = fin;
      case (op)
         OP_ADD_WITH_CARRY_IN_F, OP_ADD_WITH_CARRY_IN_L10, OP_ADD_WITH_CARRY_IN_W, OP_ADD_WITH_CARRY_IN_L5:
         begin
            r = sum[15:0];
            res.flags.c = sum[16];
            res.flags.dc = nib[4];
            res.flags.n = r[15];
            res.flags.ov = (opa[15] == opb[15]) && (r[15] != opa[15]);
            res.flags.z = fin.z & (r == ZERO16);
         end
         OP_ASR_F, OP_ASR_W:
         begin
            r = {opa[15], opa[15:1]};
            res.flags.c = opa[0];
            res.flags.n = r[15];
            res.flags.ov = 1'b0;
            res.flags.z = (r == ZERO16);
         end
         OP_ASR_WN, OP_ASR_L5:
         begin
            r = 16'($signed(opa) >>> shamt);
            res.flags.n = r[15];
            res.flags.z = (r == ZERO16);
         end
         OP_AND_W:
         begin
            r = opa & opb;
            res.flags.n = r[15];
            res.flags.z = (r == ZERO16);
         end
         OP_BIT_CLEAR_W, OP_BIT_CLEAR_F:
         begin
            r = opa & ~(16'h0001 << shamt[3:0]);
         end
         default:
         begin
            r = opa;
         end
      endcase
      res.result = r;
   end
endmodule // alu_unit

// ---- test/core_alu_asserts.sv ----
// Purpose: Port checks on the register bus of the datapath slice
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every core_alu instance
`timescale 1ns/100ps
module core_alu_asserts
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   import alu_pkg::*;
   logic ack;
   logic cmd_seen;
   logic [5:0] last_addr;
   logic [15:0] last_data;
   assign ack = !waitrequest;
   // Last plain register write, forgotten once a command runs
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_seen <= 1'b0;
         last_addr <= 6'h3F;
         last_data <= 16'h0000;
      end
      else if (write && ack)
      begin
         cmd_seen <= cmd_seen || (address == REG_CMD);
         last_addr <= (address == REG_CMD) ? 6'h3F : address;
         last_data <= writedata[15:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_one_wait_cycle: assert property (($rose(read) || $rose(write)) |-> waitrequest ##1 ack)
      else $error("request not answered after one wait cycle");
   a_ack_one_cycle: assert property (ack |=> waitrequest)
      else $error("answer held longer than one cycle");
   a_ack_needs_req: assert property (ack |-> (read || write) && $past(read || write))
      else $error("answer without a request");
   // holes and space beyond the last register
   a_gap_unmapped: assert property (read && ack && address > REG_PFY
      && address < REG_WBASE |-> readdata == BAD_READ)
      else $error("hole in the map did not return the error word");
   a_beyond_regs: assert property (read && ack && address[5] |-> readdata == BAD_READ)
      else $error("address past the last register did not return the error word");
   a_readdata_holds: assert property (!read && !$past(read) |-> $stable(readdata))
      else $error("read data changed without a read");
   a_reg_readback: assert property (read && ack && address == last_addr
      && (address == REG_FREG || address[5:4] == 2'b01) |-> readdata[15:0] == last_data)
      else $error("register did not read back its written value");
   // flags and accumulators clear from reset
   a_reset_flags: assert property (read && ack && !cmd_seen && address == REG_STATUS
      |-> readdata[11:0] == 12'h000)
      else $error("status not clear before the first command");
   a_reset_accs: assert property (read && ack && !cmd_seen
      && (address == REG_ACCA_LO || address == REG_ACCB_LO) |-> readdata == 32'h0000_0000)
      else $error("accumulator not clear before the first command");
endmodule // core_alu_asserts

bind core_alu core_alu_asserts i_core_alu_asserts
(
   .clk(clk),
   .rst_b(rst_b),
   .address(address),
   .read(read),
   .write(write),
   .writedata(writedata),
   .readdata(readdata),
   .waitrequest(waitrequest)
);

// ---- test/core_alu_tb.sv ----
// Purpose: Self-checking bench for the operand and ALU slice
// Assumes: Bus answers after one wait cycle, commands go through CMD
// Notes: Expected flags are carried by hand from one command to the next
`timescale 1ns/100ps
module core_alu_tb;
   import alu_pkg::*;
   logic clk;
   logic rst_b;
   logic [5:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic [31:0] rd_val;
   logic busy1;
   int error_cnt;
   int compares;
   logic [11:0] mt [7] = '{12'h440, 12'h770, 12'h450, 12'h670, 12'h221, 12'h781, 12'h541};

   core_alu i_core_alu
   (
      .clk(clk),
      .rst_b(rst_b),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic finish_test();
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [5:0] w(input int n);
      return REG_WBASE | 6'(n);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
      begin
         error_cnt++;
         $display("[ERR] %0t no answer", $time);
      end
      rd_val = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic set(input logic [5:0] a, input logic [15:0] v);
      bus(1'b1, a, {16'h0000, v});
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'h0000_FFFF);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd_val & m, e);
   endtask

   task automatic cmd(input op_t op, input logic [3:0] s, input logic [3:0] b,
      input logic [3:0] d, input logic [9:0] l = 10'h000, input logic t = 1'b0,
      input logic ac = 1'b0);
      int n;
      n = 0;
      bus(1'b1, REG_CMD, {ac, t, l, d, b, s, 4'h0, op});
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      busy1 = rd_val[S_BUSY];
      while (rd_val[S_BUSY] !== 1'b0 && n < 8)
      begin
         bus(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
      end
      chk(32'(rd_val[S_BUSY]), 32'h0);
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      $display("[ERR] %0t watchdog", $time);
      finish_test();
   end

   initial
   begin
      rst_b = 1'b0;
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      error_cnt = 0;
      compares = 0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(REG_STATUS, 32'h0, 32'hFFF);
      rdc(REG_ACCA_LO, 32'h0, 32'hFFFF_FFFF);
      set(6'h09, 16'h1234);
      rdc(6'h09, BAD_READ, 32'hFFFF_FFFF);
      rdc(6'h20, BAD_READ, 32'hFFFF_FFFF);
      for (int i = 0; i < 16; i++)
         set(w(i), 16'hA500 | 16'(i));
      for (int i = 0; i < 16; i++)
         rdc(w(i), 32'hA500 + 32'(i));
      set(REG_FREG, 16'hFFFF);
      set(w(0), 16'h0001);
      cmd(OP_ADD_WITH_CARRY_IN_F, 4'h0, 4'h0, 4'h0);
      rdc(REG_FREG, 32'h0000);
      rdc(REG_STATUS, 32'h11, 32'h1FF);
      set(w(2), 16'h0100);
      cmd(OP_ADD_WITH_CARRY_IN_L10, 4'h2, 4'h2, 4'h2, 10'h3FF);
      rdc(w(2), 32'h0500);
      rdc(REG_STATUS, 32'h10, 32'h1FF);
      set(REG_FREG, 16'h0003);
      cmd(OP_ADD_WITH_CARRY_IN_F, 4'h0, 4'h0, 4'h0, 10'h000, 1'b1);
      rdc(w(0), 32'h0004);
      rdc(REG_FREG, 32'h0003);
      rdc(REG_STATUS, 32'h00, 32'h1FF);
      set(w(1), 16'h8000);
      set(w(3), 16'h8000);
      cmd(OP_ADD_WITH_CARRY_IN_W, 4'h3, 4'h1, 4'h5);
      rdc(w(5), 32'h0000);
      rdc(REG_STATUS, 32'h05, 32'h1FF);
      cmd(OP_ADD_WITH_CARRY_IN_L5, 4'h0, 4'h1, 4'h6, 10'h01F);
      rdc(w(6), 32'h8020);
      rdc(REG_STATUS, 32'h18, 32'h1FF);
      set(REG_FREG, 16'h8001);
      cmd(OP_ASR_F, 4'h0, 4'h0, 4'h0);
      rdc(REG_FREG, 32'hC000);
      rdc(REG_STATUS, 32'h19, 32'h1FF);
      set(REG_FREG, 16'h0001);
      cmd(OP_ASR_F, 4'h0, 4'h0, 4'h0, 10'h000, 1'b1);
      rdc(w(0), 32'h0000);
      rdc(REG_FREG, 32'h0001);
      rdc(REG_STATUS, 32'h13, 32'h1FF);
      set(w(9), 16'hF000);
      set(w(10), 16'h0004);
      cmd(OP_ASR_WN, 4'hA, 4'h9, 4'hB);
      rdc(w(11), 32'hFF00);
      rdc(REG_STATUS, 32'h19, 32'h1FF);
      set(w(7), 16'h4000);
      cmd(OP_ASR_W, 4'h7, 4'h7, 4'h8);
      rdc(w(8), 32'h2000);
      rdc(REG_STATUS, 32'h10, 32'h1FF);
      set(w(12), 16'h0001);
      cmd(OP_ASR_L5, 4'h0, 4'hC, 4'hD, 10'h001);
      rdc(w(13), 32'h0000);
      rdc(REG_STATUS, 32'h12, 32'h1FF);
      cmd(OP_ASR_L5, 4'h0, 4'h9, 4'hD, 10'h011);
      rdc(w(13), 32'hFFFF);
      rdc(REG_STATUS, 32'h18, 32'h1FF);
      set(w(14), 16'hF0F0);
      set(w(15), 16'h8F00);
      cmd(OP_AND_W, 4'hF, 4'hE, 4'hD);
      rdc(w(13), 32'h8000);
      rdc(REG_STATUS, 32'h18, 32'h1FF);
      cmd(OP_BIT_CLEAR_W, 4'hD, 4'hD, 4'hD, 10'h00F);
      rdc(w(13), 32'h0000);
      set(REG_FREG, 16'h4001);
      cmd(OP_BIT_CLEAR_F, 4'h0, 4'h0, 4'h0, 10'h000);
      rdc(REG_FREG, 32'h4000);
      rdc(REG_STATUS, 32'h18, 32'h1FF);
      // carry branch taken only on carry
      cmd(OP_BRA_C, 4'h0, 4'h0, 4'h0);
      rdc(REG_STATUS, 32'h0, 32'h400);
      chk(32'(busy1), 32'h0);
      set(REG_FREG, 16'h0001);
      cmd(OP_ASR_F, 4'h0, 4'h0, 4'h0);
      cmd(OP_BRA_C, 4'h0, 4'h0, 4'h0);
      rdc(REG_STATUS, 32'h400, 32'h400);
      chk(32'(busy1), 32'h1);
      cmd(OP_ACC_ADD, 4'h2, 4'h2, 4'h0);
      rdc(REG_ACCA_LO, 32'h0500_0000, 32'hFFFF_FFFF);
      cmd(OP_ACC_ADD, 4'h1, 4'h1, 4'h0, 10'h000, 1'b0, 1'b1);
      rdc(REG_ACCB_LO, 32'h8000_0000, 32'hFFFF_FFFF);
      rdc(REG_STATUS, 32'h13, 32'h1FF);
      cmd(OP_ACC_ADD, 4'h1, 4'h1, 4'h0, 10'h008, 1'b0, 1'b1);
      rdc(REG_ACCB_LO, 32'h0000_0000, 32'hFFFF_FFFF);
      rdc(REG_STATUS, 32'h153, 32'h1FF);
      foreach (mt[i])
      begin
         cmd(OP_MUL, mt[i][7:4], mt[i][11:8], 4'h0);
         rdc(REG_STATUS, 32'(mt[i][0]) << S_ILLEGAL, 32'h800);
      end
      set(w(8), 16'h0100);
      cmd(OP_PREFETCH, 4'h0, 4'h0, 4'h0, 10'h003);
      rdc(w(8), 32'h0106);
      rdc(REG_PFX, 32'h0100);
      rdc(w(4), 32'h0100);
      set(w(11), 16'h0200);
      cmd(OP_PREFETCH, 4'h0, 4'h0, 4'h1, 10'h20F);
      rdc(w(11), 32'h01FA);
      rdc(REG_PFY, 32'h0200);
      rdc(w(5), 32'h0200);
      cmd(OP_PREFETCH, 4'h0, 4'h0, 4'h2, 10'h00C);
      rdc(REG_PFX, 32'hF001);
      rdc(w(9), 32'hF000);
      rdc(w(6), 32'hF001);
      cmd(OP_PREFETCH, 4'h0, 4'h0, 4'h0, 10'h004);
      rdc(REG_STATUS, 32'h800, 32'h800);
      finish_test();
   end
endmodule // core_alu_tb
